// ---- rtl/scm_pkg.sv ----
// package: register map, field positions and timing for the serial controller block
package scm_pkg;
	// register byte addresses
	localparam logic [15:0] ADDR_DMA_CONTROL = 16'h4418;
	localparam logic [15:0] ADDR_SERIAL_STATUS = 16'h4420;
	localparam logic [15:0] ADDR_TWO_WIRE_STATUS = 16'h4422;
	localparam logic [15:0] ADDR_TWO_WIRE_COMMAND = 16'h4426;
	localparam logic [15:0] ADDR_TWO_WIRE_ACK_SELECT = 16'h4428;
	localparam logic [15:0] ADDR_SERIAL_DATA = 16'h443C;
	// command register fields
	localparam int CMD_STOP_BIT = 3;
	localparam int CMD_START_BIT = 2;
	localparam int CMD_SEND_BIT = 1;
	localparam int CMD_RECV_BIT = 0;
	// status register fields
	localparam int ST_CMD_FIN_BIT = 3;
	localparam int ST_RX_FIN_BIT = 2;
	localparam int ST_TX_FIN_BIT = 1;
	localparam int ST_RX_NACK_BIT = 0;
	// ack select field
	localparam int ACK_SEL_BIT = 0;
	// serial status field
	localparam int SPI_RX_OVF_BIT = 0;
	// dma control fields
	localparam int DMA_TX_RST_BIT = 5;
	localparam int DMA_RX_RST_BIT = 4;
	localparam int DMA_TX_B_BIT = 3;
	localparam int DMA_TX_A_BIT = 2;
	localparam int DMA_RX_B_BIT = 1;
	localparam int DMA_RX_A_BIT = 0;
	// reset values
	localparam logic [3:0] CMD_RESET = 4'h0;
	localparam logic [3:0] STAT_RESET = 4'h0;
	localparam logic [3:0] LOAD_RESET = 4'h0;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int QUARTER_BIT_NS = 2500;
	localparam int QUARTER_BIT_CYCLES = QUARTER_BIT_NS / CLK_PERIOD_NS;
endpackage : scm_pkg

// ---- rtl/scm_serial_ctrl.sv ----
// serial controller: command driven two wire master, dma load control, rx overrun flag
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module scm_serial_ctrl #(
	parameter int QUARTER_CYCLES = scm_pkg::QUARTER_BIT_CYCLES
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [15:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	input wire logic RX_FIFO_OVERFLOW_I,
	input wire logic [7:0] TX_BYTE_I,
	output logic [7:0] RX_BYTE_O,
	input wire logic TX_DMA_DONE_A_I,
	input wire logic TX_DMA_DONE_B_I,
	input wire logic RX_DMA_DONE_A_I,
	input wire logic RX_DMA_DONE_B_I,
	output logic TX_DMA_RESET_O,
	output logic RX_DMA_RESET_O,
	output logic [3:0] DMA_START_O,
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE_N_O,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_STOP,
		ST_BIT,
		ST_ACK
	} scm_state_e;

	scm_state_e state_reg;
	logic [3:0] cmd_reg;
	logic [3:0] stat_reg;
	logic ack_sel_reg;
	logic ovf_reg;
	logic [3:0] load_reg;
	logic tx_rst_reg;
	logic rx_rst_reg;
	logic [3:0] dma_start_reg;
	logic [15:0] rdata_reg;
	logic [7:0] shift_reg;
	logic [7:0] rx_byte_reg;
	logic [2:0] bit_cnt_reg;
	logic [1:0] phase_reg;
	logic [15:0] tick_cnt_reg;
	logic tick;
	logic scl_drive_low_reg;
	logic sda_drive_low_reg;
	logic bus_held_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] scl_sync_reg;
	logic sda_in;
	logic scl_in;
	logic wr_cmd;
	logic cmd_start;
	logic cmd_done;
	logic [3:0] load_done;

	// reads a 16 bit value shaped from a narrow field
	function automatic logic [15:0] widen4(input logic [3:0] v);
		widen4 = {12'h000, v};
	endfunction

	// true when a strobe addresses the given register
	function automatic logic reg_hit(input logic strobe, input logic [15:0] addr, input logic [15:0] target);
		reg_hit = strobe && (addr == target);
	endfunction

	// three stage pin synchronisers, a change counts when stages two and three agree
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sda_sync_reg <= 3'h7;
			scl_sync_reg <= 3'h7;
		end else begin
			sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
			scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
		end
	end

	// filtered levels hold until stages two and three agree
	logic sda_filt_reg;
	logic scl_filt_reg;
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sda_filt_reg <= 1'b1;
			scl_filt_reg <= 1'b1;
		end else begin
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_filt_reg <= sda_sync_reg[2];
			end
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_filt_reg <= scl_sync_reg[2];
			end
		end
	end
	assign sda_in = sda_filt_reg;
	assign scl_in = scl_filt_reg;

	// quarter bit tick, stalls while a slave stretches the clock
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || state_reg == ST_IDLE) begin
			tick_cnt_reg <= 16'h0000;
		end else if (!scl_drive_low_reg && !scl_in) begin
			tick_cnt_reg <= tick_cnt_reg;
		end else if (tick) begin
			tick_cnt_reg <= 16'h0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end
	assign tick = (tick_cnt_reg == 16'(QUARTER_CYCLES - 1));

	assign wr_cmd = reg_hit(WR_I, ADDR_I, scm_pkg::ADDR_TWO_WIRE_COMMAND);
	assign cmd_start = (state_reg == ST_IDLE) && (cmd_reg != 4'h0);

	// two wire sequencer: start, stop, eight data bits then acknowledge
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			state_reg <= ST_IDLE;
			phase_reg <= 2'h0;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			scl_drive_low_reg <= 1'b0;
			sda_drive_low_reg <= 1'b0;
			bus_held_reg <= 1'b0;
			rx_byte_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					phase_reg <= 2'h0;
					bit_cnt_reg <= 3'h7;
					if (cmd_reg[scm_pkg::CMD_START_BIT]) begin
						state_reg <= ST_START;
					end else if (cmd_reg[scm_pkg::CMD_STOP_BIT]) begin
						state_reg <= ST_STOP;
					end else if (cmd_reg[scm_pkg::CMD_SEND_BIT]) begin
						shift_reg <= TX_BYTE_I;
						state_reg <= ST_BIT;
					end else if (cmd_reg[scm_pkg::CMD_RECV_BIT]) begin
						shift_reg <= 8'hFF;
						state_reg <= ST_BIT;
					end
				end
				ST_START: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: sda_drive_low_reg <= 1'b0; // repeated start releases data first
							2'h1: scl_drive_low_reg <= 1'b0;
							2'h2: sda_drive_low_reg <= 1'b1; // data falls while clock high
							default: begin
								scl_drive_low_reg <= 1'b1;
								bus_held_reg <= 1'b1;
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_STOP: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: begin
								// a free bus has nothing to stop; pulling data low would fake a start
								sda_drive_low_reg <= bus_held_reg;
							end
							2'h1: scl_drive_low_reg <= 1'b0;
							2'h2: sda_drive_low_reg <= 1'b0; // data rises while clock high
							default: begin
								bus_held_reg <= 1'b0;
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_BIT: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: sda_drive_low_reg <= !shift_reg[7];
							2'h1: scl_drive_low_reg <= 1'b0;
							2'h2: shift_reg <= {shift_reg[6:0], sda_in};
							default: begin
								scl_drive_low_reg <= 1'b1;
								bit_cnt_reg <= bit_cnt_reg - 3'h1;
								if (bit_cnt_reg == 3'h0) begin
									state_reg <= ST_ACK;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (tick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: begin
								if (cmd_reg[scm_pkg::CMD_RECV_BIT]) begin
									sda_drive_low_reg <= ack_sel_reg;
									rx_byte_reg <= shift_reg;
								end else begin
									sda_drive_low_reg <= 1'b0;
								end
							end
							2'h1: scl_drive_low_reg <= 1'b0;
							2'h2: shift_reg[0] <= sda_in;
							default: begin
								scl_drive_low_reg <= 1'b1;
								sda_drive_low_reg <= 1'b0;
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign cmd_done = tick && (phase_reg == 2'h3) &&
		(state_reg == ST_START || state_reg == ST_STOP || state_reg == ST_ACK);

	// command bits: set by write, self-clear at completion
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			cmd_reg <= scm_pkg::CMD_RESET;
		end else if (cmd_done) begin
			cmd_reg <= 4'h0;
		end else if (wr_cmd && state_reg == ST_IDLE && cmd_reg == 4'h0) begin
			cmd_reg <= WDATA_I[3:0];
		end
	end

	// completion flags: set at end of command, clear when the next one starts
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			stat_reg <= scm_pkg::STAT_RESET;
		end else if (cmd_done) begin
			stat_reg[scm_pkg::ST_CMD_FIN_BIT] <= (state_reg != ST_ACK);
			stat_reg[scm_pkg::ST_RX_FIN_BIT] <= (state_reg == ST_ACK) && cmd_reg[scm_pkg::CMD_RECV_BIT];
			stat_reg[scm_pkg::ST_TX_FIN_BIT] <= (state_reg == ST_ACK) && cmd_reg[scm_pkg::CMD_SEND_BIT];
			stat_reg[scm_pkg::ST_RX_NACK_BIT] <= (state_reg == ST_ACK) && cmd_reg[scm_pkg::CMD_SEND_BIT] &&
				shift_reg[0];
		end else if (cmd_start) begin
			stat_reg <= 4'h0;
		end
	end

	// acknowledge select register
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ack_sel_reg <= 1'b0;
		end else if (reg_hit(WR_I, ADDR_I, scm_pkg::ADDR_TWO_WIRE_ACK_SELECT)) begin
			ack_sel_reg <= WDATA_I[scm_pkg::ACK_SEL_BIT];
		end
	end

	// receive fifo overrun flag, a new overflow wins over the clearing read
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ovf_reg <= 1'b0;
		end else if (RX_FIFO_OVERFLOW_I) begin
			ovf_reg <= 1'b1;
		end else if (reg_hit(RD_I, ADDR_I, scm_pkg::ADDR_SERIAL_DATA)) begin
			ovf_reg <= 1'b0;
		end
	end

	assign load_done = {TX_DMA_DONE_B_I, TX_DMA_DONE_A_I, RX_DMA_DONE_B_I, RX_DMA_DONE_A_I};

	// dma load bits, reset pulses and start pulses
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			load_reg <= scm_pkg::LOAD_RESET;
			tx_rst_reg <= 1'b0;
			rx_rst_reg <= 1'b0;
			dma_start_reg <= 4'h0;
		end else begin
			tx_rst_reg <= 1'b0;
			rx_rst_reg <= 1'b0;
			dma_start_reg <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				if (reg_hit(WR_I, ADDR_I, scm_pkg::ADDR_DMA_CONTROL) && WDATA_I[i]) begin
					load_reg[i] <= 1'b1;
					dma_start_reg[i] <= !load_reg[i];
				end else if (load_done[i]) begin
					load_reg[i] <= 1'b0;
				end
			end
			if (reg_hit(WR_I, ADDR_I, scm_pkg::ADDR_DMA_CONTROL)) begin
				tx_rst_reg <= WDATA_I[scm_pkg::DMA_TX_RST_BIT];
				rx_rst_reg <= WDATA_I[scm_pkg::DMA_RX_RST_BIT];
				if (WDATA_I[scm_pkg::DMA_TX_RST_BIT]) begin
					load_reg[scm_pkg::DMA_TX_B_BIT] <= 1'b0;
					load_reg[scm_pkg::DMA_TX_A_BIT] <= 1'b0;
					dma_start_reg[scm_pkg::DMA_TX_B_BIT] <= 1'b0;
					dma_start_reg[scm_pkg::DMA_TX_A_BIT] <= 1'b0;
				end
				if (WDATA_I[scm_pkg::DMA_RX_RST_BIT]) begin
					load_reg[scm_pkg::DMA_RX_B_BIT] <= 1'b0;
					load_reg[scm_pkg::DMA_RX_A_BIT] <= 1'b0;
					dma_start_reg[scm_pkg::DMA_RX_B_BIT] <= 1'b0;
					dma_start_reg[scm_pkg::DMA_RX_A_BIT] <= 1'b0;
				end
			end
		end
	end

	// read data one cycle after the read strobe, unmapped reads zero
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			rdata_reg <= 16'h0000;
		end else if (RD_I) begin
			if (ADDR_I == scm_pkg::ADDR_DMA_CONTROL) begin
				rdata_reg <= widen4(load_reg);
			end else if (ADDR_I == scm_pkg::ADDR_SERIAL_STATUS) begin
				rdata_reg <= {15'h0000, ovf_reg};
			end else if (ADDR_I == scm_pkg::ADDR_TWO_WIRE_STATUS) begin
				rdata_reg <= widen4(stat_reg);
			end else if (ADDR_I == scm_pkg::ADDR_TWO_WIRE_COMMAND) begin
				rdata_reg <= widen4(cmd_reg);
			end else if (ADDR_I == scm_pkg::ADDR_TWO_WIRE_ACK_SELECT) begin
				rdata_reg <= {15'h0000, ack_sel_reg};
			end else if (ADDR_I == scm_pkg::ADDR_SERIAL_DATA) begin
				rdata_reg <= {8'h00, rx_byte_reg};
			end else begin
				rdata_reg <= 16'h0000;
			end
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// outputs; open drain pins pull low only, enable low while driving
	assign RDATA_O = rdata_reg;
	assign RX_BYTE_O = rx_byte_reg;
	assign TX_DMA_RESET_O = tx_rst_reg;
	assign RX_DMA_RESET_O = rx_rst_reg;
	assign DMA_START_O = dma_start_reg;
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE_N_O = !scl_drive_low_reg;
	assign SDA_OE_N_O = !sda_drive_low_reg;
endmodule // scm_serial_ctrl

// ---- verif/scm_i2c_slave.sv ----
// slave model: two wire target with ack, nack, read data and clock stretch
`timescale 1ns/100ps
module scm_i2c_slave (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic nack_i,
	input wire logic slow_i,
	input wire logic rd_i,
	input wire logic [7:0] tx_i,
	output logic scl_oe_n_o,
	output logic sda_oe_n_o,
	output logic [7:0] rx_o,
	output logic ack_o
);
	int n = 0;
	logic rd_mode = 1'b0;
	logic go = 1'b0;
	initial begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
		rx_o = 8'h00;
		ack_o = 1'b0;
	end
	// start: data falls while clock high, latch direction
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		n = 0;
		go = 1'b1;
		rd_mode = rd_i;
	end
	// sample bits msb first, then the ack slot
	always @(posedge scl_i) begin
		if (n < 8) rx_o = {rx_o[6:0], sda_i};
		else ack_o = !sda_i;
		if (n == 8 && rd_mode && sda_i) go = 1'b0;  // master nack ends the read
		n++;
	end
	// drive on falling clock, release when not owning data
	always @(negedge scl_i) begin
		if (n == 9) n = 0;
		if (n == 8) sda_oe_n_o = rd_mode | nack_i;
		else sda_oe_n_o = !(rd_mode && go) | tx_i[7 - n];
		if (slow_i) begin
			scl_oe_n_o = 1'b0;
			#200 scl_oe_n_o = 1'b1;
		end
	end
endmodule // scm_i2c_slave

// ---- verif/scm_properties.sv ----
// checker: port level properties of the serial controller
`timescale 1ns/100ps
module scm_properties #(
	parameter int QUARTER_CYCLES = 4
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [15:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic TX_DMA_RESET_O,
	input wire logic RX_DMA_RESET_O,
	input wire logic [3:0] DMA_START_O,
	input wire logic SCL_OE_N_O,
	input wire logic SDA_OE_N_O
);
	localparam int WAIT_MAX = 16 * QUARTER_CYCLES + 40;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	// write decode and load field
	logic dma_wr;
	logic cmd_wr;
	logic [3:0] load_bits;
	assign dma_wr = WR_I && ADDR_I == scm_pkg::ADDR_DMA_CONTROL;
	assign cmd_wr = WR_I && ADDR_I == scm_pkg::ADDR_TWO_WIRE_COMMAND;
	assign load_bits = WDATA_I[3:0];
	// command requests and bus states
	sequence start_req; cmd_wr && WDATA_I[2]; endsequence
	sequence stop_req; cmd_wr && WDATA_I[3:2] == 2'h2; endsequence
	sequence held_bus; !SDA_OE_N_O && SCL_OE_N_O; endsequence
	sequence free_bus; SDA_OE_N_O && SCL_OE_N_O; endsequence
	a_start_pulls_data: assert property (start_req |-> ##[1:WAIT_MAX] held_bus)
		else $error("start not seen on pins");
	a_stop_frees_bus: assert property (stop_req |-> ##[1:WAIT_MAX] free_bus)
		else $error("stop did not free the bus");
	a_tx_reset_pulse: assert property (dma_wr && WDATA_I[5] |=> TX_DMA_RESET_O ##1 !TX_DMA_RESET_O)
		else $error("tx dma reset pulse wrong");
	a_rx_reset_pulse: assert property (dma_wr && WDATA_I[4] |=> RX_DMA_RESET_O ##1 !RX_DMA_RESET_O)
		else $error("rx dma reset pulse wrong");
	a_reset_has_cause: assert property (TX_DMA_RESET_O || RX_DMA_RESET_O |-> $past(dma_wr))
		else $error("dma reset without write");
	a_load_zero_idle: assert property (dma_wr && load_bits == 4'h0 |=> DMA_START_O == 4'h0)
		else $error("zero load write started dma");
	a_start_one_shot: assert property (DMA_START_O != 4'h0 |=> DMA_START_O == 4'h0)
		else $error("dma start longer than one cycle");
	a_status_upper_zero: assert property (RD_I && ADDR_I == scm_pkg::ADDR_TWO_WIRE_STATUS
		|=> RDATA_O[15:4] == 12'h000)
		else $error("status upper bits not zero");
endmodule // scm_properties

bind scm_serial_ctrl scm_properties #(.QUARTER_CYCLES(QUARTER_CYCLES)) scm_properties_inst (
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .RDATA_O(RDATA_O), .TX_DMA_RESET_O(TX_DMA_RESET_O), .RX_DMA_RESET_O(RX_DMA_RESET_O),
	.DMA_START_O(DMA_START_O), .SCL_OE_N_O(SCL_OE_N_O), .SDA_OE_N_O(SDA_OE_N_O));

// ---- verif/scm_serial_ctrl_bench.sv ----
// bench: registers, dma loads and two wire commands of the serial controller
`timescale 1ns/100ps
module scm_serial_ctrl_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ovf = 1'b0;
	logic nack = 1'b0;
	logic slow = 1'b0;
	logic s_rd = 1'b0;
	logic s_ack;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] v;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] s_rx;
	logic [3:0] done = 4'h0;
	logic [3:0] load = 4'h0;
	logic [3:0] d;
	logic [3:0] st_exp;
	logic [3:0] dma_start;
	logic [7:0] rx_byte;
	logic scl_oe_n;
	logic sda_oe_n;
	logic s_scl_oe_n;
	logic s_sda_oe_n;
	wire scl = scl_oe_n & s_scl_oe_n;  // pulled up when released
	wire sda = sda_oe_n & s_sda_oe_n;
	int seed = 32'h03B868AC;
	int n_fail = 0;
	int check_count = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	scm_serial_ctrl #(.QUARTER_CYCLES(4)) scm_serial_ctrl_inst (
		.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .RX_FIFO_OVERFLOW_I(ovf), .TX_BYTE_I(tx_byte), .RX_BYTE_O(rx_byte),
		.TX_DMA_DONE_B_I(done[3]), .TX_DMA_DONE_A_I(done[2]), .RX_DMA_DONE_B_I(done[1]),
		.RX_DMA_DONE_A_I(done[0]), .TX_DMA_RESET_O(), .RX_DMA_RESET_O(), .DMA_START_O(dma_start),
		.SCL_I(scl), .SCL_O(), .SCL_OE_N_O(scl_oe_n), .SDA_I(sda), .SDA_O(), .SDA_OE_N_O(sda_oe_n));
	scm_i2c_slave scm_i2c_slave_inst (.scl_i(scl), .sda_i(sda), .nack_i(nack), .slow_i(slow),
		.rd_i(s_rd), .tx_i(~tx_byte), .scl_oe_n_o(s_scl_oe_n), .sda_oe_n_o(s_sda_oe_n),
		.rx_o(s_rx), .ack_o(s_ack));
	// compare and count
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// counts and verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one cycle register write
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] dat);
		@(posedge clk);
		addr <= a;
		wdata <= dat;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one cycle register read, data taken the cycle after
	task automatic rd_reg(input logic [15:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// issue a command, poll until it clears, then check status
	task automatic cmd(input logic [3:0] c, input logic [3:0] st);
		wr_reg(scm_pkg::ADDR_TWO_WIRE_COMMAND, {12'h000, c});
		for (int i = 0; i < 400; i++) begin
			rd_reg(scm_pkg::ADDR_TWO_WIRE_COMMAND);
			if (v === 16'h0000) break;
		end
		check("command bits", v, 16'h0000);
		if (v !== 16'h0000) end_sim();
		rd_reg(scm_pkg::ADDR_TWO_WIRE_STATUS);
		check("status", v, {12'h000, st});
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// reset values and an unmapped address
		rd_reg(scm_pkg::ADDR_TWO_WIRE_STATUS);
		check("status reset", v, 16'h0000);
		rd_reg(16'h4400);
		check("unmapped", v, 16'h0000);
		// overrun sets, data read clears
		@(posedge clk) ovf <= 1'b1;
		@(posedge clk) ovf <= 1'b0;
		rd_reg(scm_pkg::ADDR_SERIAL_STATUS);
		check("overrun set", v, 16'h0001);
		rd_reg(scm_pkg::ADDR_SERIAL_DATA);
		rd_reg(scm_pkg::ADDR_SERIAL_STATUS);
		check("overrun clear", v, 16'h0000);
		// dma load bits: random writes, resets and completions
		for (int i = 0; i < 40; i++) begin
			v = 16'($random(seed));
			if (i == 0) v = 16'hFFCF;
			if (i == 1) v = 16'h0000;
			if (v[5]) v[3:2] = 2'h0;
			if (v[4]) v[1:0] = 2'h0;
			st_exp = v[3:0] & ~load;
			wr_reg(scm_pkg::ADDR_DMA_CONTROL, v);
			@(negedge clk) check("dma start", {12'h000, dma_start}, {12'h000, st_exp});
			load = (load & ~{v[5], v[5], v[4], v[4]}) | v[3:0];
			rd_reg(scm_pkg::ADDR_DMA_CONTROL);
			check("dma load", v, {12'h000, load});
			d = 4'($random(seed));
			@(posedge clk) done <= d;
			@(posedge clk) done <= 4'h0;
			load = load & ~d;
			rd_reg(scm_pkg::ADDR_DMA_CONTROL);
			check("dma done", v, {12'h000, load});
		end
		// two wire traffic against the slave model
		@(posedge clk) tx_byte <= 8'($random(seed));
		wr_reg(scm_pkg::ADDR_TWO_WIRE_ACK_SELECT, 16'hFFFF);
		rd_reg(scm_pkg::ADDR_TWO_WIRE_ACK_SELECT);
		check("ack select", v, 16'h0001);
		cmd(4'h8, 4'h8);
		cmd(4'h4, 4'h8);
		cmd(4'h2, 4'h2);
		check("slave byte", {8'h00, s_rx}, {8'h00, tx_byte});
		nack <= 1'b1;
		slow <= 1'b1;
		cmd(4'h2, 4'h3);
		nack <= 1'b0;
		s_rd <= 1'b1;
		cmd(4'h4, 4'h8);
		cmd(4'h1, 4'h4);
		check("master ack", {15'h0000, s_ack}, 16'h0001);
		rd_reg(scm_pkg::ADDR_SERIAL_DATA);
		check("rx byte", v, {8'h00, ~tx_byte});
		check("rx byte pin", {8'h00, rx_byte}, {8'h00, ~tx_byte});
		wr_reg(scm_pkg::ADDR_TWO_WIRE_ACK_SELECT, 16'h0000);
		cmd(4'h1, 4'h4);
		check("master nack", {15'h0000, s_ack}, 16'h0000);
		check("rx byte again", {8'h00, rx_byte}, {8'h00, ~tx_byte});
		s_rd <= 1'b0;
		cmd(4'h8, 4'h8);
		check("idle bus", {14'h0000, scl, sda}, 16'h0003);
		end_sim();
	end
endmodule // scm_serial_ctrl_bench
